// ### hdl/vdpc_cfg.svh
// Constants for the video decoder pin control block
`ifndef VDPC_CFG_SVH
`define VDPC_CFG_SVH
`define VDPC_VID_W          10
`define VDPC_VID8_MSB       9
`define VDPC_VID8_LSB       2
`define VDPC_SYNC_SRC_EXT   2'h0
`define VDPC_BANK_LOW_FIRST 8'h17
`define VDPC_BANK_LOW_LAST  8'h1F
`define VDPC_BANK_HIGH_FIRST 8'h27
`define VDPC_BANK_HIGH_LAST 8'h2F
`define VDPC_BANK_OFFSET    8'h10
`define VDPC_MODE_ADAPTIVE  2'h0
`define VDPC_MODE_BANDSPLIT 2'h1
`define VDPC_MODE_NONADAPT  2'h2
`define VDPC_MODE_NOTCH     2'h3
`define VDPC_FUNC_W         4
`define VDPC_FUNC_RESET     4'h0
`endif

// ### hdl/vdpc_pkg.sv
// Types for the video decoder pin control block
package vdpc_pkg;
  typedef enum logic [1:0] {
    VDPC_DEC_ADAPTIVE  = 2'b00,
    VDPC_DEC_BANDSPLIT = 2'b01,
    VDPC_DEC_NONADAPT  = 2'b10,
    VDPC_DEC_NOTCH     = 2'b11
  } vdpc_dec_mode_e;
  typedef enum logic [1:0] {
    VDPC_RUN_DISABLED = 2'b00,
    VDPC_RUN_NORMAL   = 2'b01,
    VDPC_RUN_FUNCTION = 2'b10
  } vdpc_run_e;
  typedef logic [9:0] vdpc_pixel_t;
  typedef logic [3:0] vdpc_func_t;
endpackage

// ### hdl/vdpc_sync2.sv
// Two-stage pin synchroniser, one per bit
`timescale 1ns/100ps
module vdpc_sync2 #(
  parameter int W        = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         core_clk_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        nxt_meta[i] = d_in[i];
        nxt_q[i]    = meta_ff[i];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      meta_ff <= INIT;
      q_ff    <= INIT;
    end else begin
      meta_ff <= nxt_meta;
      q_ff    <= nxt_q;
    end
  end

  assign q_out = q_ff;
endmodule

// ### hdl/vdpc_top.sv
// Pin-level input and control logic of the video decoder
`timescale 1ns/100ps
`include "vdpc_cfg.svh"

// Overview of operation
// - Both video buses are 10-bit; 8-bit parts use bits 9 to 2.
// - Coincident falling edges of vertical and horizontal sync mark field 1.
// - Vertical sync input used only when sync source selection is 00.
// - Horizontal sync active low, honoured only when sync source is 00.
// - Two decoder-type pins choose one of four decoding modes.
// - Bank pin low selects matrix registers 17 to 1F.
// - Bank pin high selects matrix registers 27 to 2F.
// - Clock-rate select bit chooses how the master clock is read.
// - Function pin low runs the function held in function register.
// - Function pin high again resumes the earlier operation.
// - Reset clears soft reset bit; outputs stay off until option high at release or soft reset set input sets the bit.
module vdpc_top (
  input  wire logic                 core_clk_in,
  input  wire logic                 reset_in,
  input  wire vdpc_pkg::vdpc_pixel_t video_in_first_in,
  input  wire vdpc_pkg::vdpc_pixel_t video_in_second_in,
  input  wire logic                 eight_bit_part_in,
  input  wire logic                 hsync_n_in,
  input  wire logic                 vsync_n_in,
  input  wire logic [1:0]           sync_source_select_in,
  input  wire logic [1:0]           decoder_type_in,
  input  wire logic                 matrix_bank_in,
  input  wire logic                 clock_rate_select_in,
  input  wire logic                 func_pin_n_in,
  input  wire vdpc_pkg::vdpc_func_t func_select_in,
  input  wire logic                 hardware_reset_option_in,
  input  wire logic                 soft_reset_set_in,
  output vdpc_pkg::vdpc_pixel_t     video_first_out,
  output vdpc_pkg::vdpc_pixel_t     video_second_out,
  output logic                      ext_hsync_out,
  output logic                      ext_vsync_out,
  output logic                      field_one_out,
  output vdpc_pkg::vdpc_dec_mode_e  decoder_mode_out,
  output logic [7:0]                matrix_reg_base_out,
  output logic                      fsc_clock_mode_out,
  output logic                      func_active_out,
  output vdpc_pkg::vdpc_func_t      func_code_out,
  output logic                      soft_reset_bit_out,
  output logic                      outputs_enable_out
);
  import vdpc_pkg::*;

  // Synchronised pin levels, reset to idle (syncs high, function pin high)
  logic [1:0] sync_raw;
  logic [1:0] sync_pins;
  logic [3:0] ctrl_raw;
  logic [3:0] ctrl_pins;
  assign sync_raw = {vsync_n_in, hsync_n_in};
  assign ctrl_raw = {func_pin_n_in, matrix_bank_in, decoder_type_in};

  vdpc_sync2 #(
    .W    (2),
    .INIT (2'h3)
  ) u_sync_pins (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .d_in        (sync_raw),
    .q_out       (sync_pins)
  );

  // Same depth as the syncs, so no pin overtakes another
  vdpc_sync2 #(
    .W    (4),
    .INIT (4'h8)
  ) u_ctrl_pins (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .d_in        (ctrl_raw),
    .q_out       (ctrl_pins)
  );

  logic       hs_s;
  logic       vs_s;
  logic [1:0] dec_s;
  logic       bank_s;
  logic       func_n_s;
  assign hs_s     = sync_pins[0];
  assign vs_s     = sync_pins[1];
  assign dec_s    = ctrl_pins[1:0];
  assign bank_s   = ctrl_pins[2];
  assign func_n_s = ctrl_pins[3];

  function automatic vdpc_pixel_t align_pixel(input vdpc_pixel_t px, input logic narrow);
    vdpc_pixel_t r;
    r = px;
    if (narrow) begin
      r[`VDPC_VID8_LSB-1:0] = 2'h0;
    end
    return r;
  endfunction

  // Falling edge of a synchronised active-low level
  function automatic logic fell_edge(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  // Qualified falling edge; dropped unless external syncs are chosen
  function automatic logic ext_pulse(input logic sel, input logic prev, input logic now);
    return sel & fell_edge(prev, now);
  endfunction

  // Mode pin code to decoder mode, also gives the reset value
  function automatic vdpc_dec_mode_e decode_mode(input logic [1:0] code);
    vdpc_dec_mode_e m;
    case (code)
      `VDPC_MODE_ADAPTIVE:  m = VDPC_DEC_ADAPTIVE;
      `VDPC_MODE_BANDSPLIT: m = VDPC_DEC_BANDSPLIT;
      `VDPC_MODE_NONADAPT:  m = VDPC_DEC_NONADAPT;
      `VDPC_MODE_NOTCH:     m = VDPC_DEC_NOTCH;
      default:              m = VDPC_DEC_ADAPTIVE;
    endcase
    return m;
  endfunction

  // Bank pin to first matrix register of the active bank
  function automatic logic [7:0] bank_base(input logic sel);
    logic [7:0] b;
    if (sel) begin
      b = `VDPC_BANK_HIGH_FIRST;
    end else begin
      b = `VDPC_BANK_LOW_FIRST;
    end
    return b;
  endfunction

  // Video data registers
  vdpc_pixel_t vid_a_ff;
  vdpc_pixel_t vid_b_ff;
  vdpc_pixel_t nxt_vid_a;
  vdpc_pixel_t nxt_vid_b;

  always_comb begin
    nxt_vid_a = align_pixel(video_in_first_in, eight_bit_part_in);
    nxt_vid_b = align_pixel(video_in_second_in, eight_bit_part_in);
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      vid_a_ff <= 10'h000;
      vid_b_ff <= 10'h000;
    end else begin
      vid_a_ff <= nxt_vid_a;
      vid_b_ff <= nxt_vid_b;
    end
  end

  // Sync handling; edge history kept only after the synchroniser
  logic hs_prev_ff;
  logic vs_prev_ff;
  logic ext_hs_ff;
  logic ext_vs_ff;
  logic field1_ff;
  logic nxt_hs_prev;
  logic nxt_vs_prev;
  logic nxt_ext_hs;
  logic nxt_ext_vs;
  logic nxt_field1;
  logic ext_sel;
  logic hs_fall;
  logic vs_fall;

  always_comb begin
    ext_sel     = (sync_source_select_in == `VDPC_SYNC_SRC_EXT);
    hs_fall     = fell_edge(hs_prev_ff, hs_s);
    vs_fall     = fell_edge(vs_prev_ff, vs_s);
    nxt_hs_prev = hs_s;
    nxt_vs_prev = vs_s;
    nxt_ext_hs  = ext_pulse(ext_sel, hs_prev_ff, hs_s);
    nxt_ext_vs  = ext_pulse(ext_sel, vs_prev_ff, vs_s);
    nxt_field1  = field1_ff;
    // Field flag only moves on a vertical edge, so it holds through the field
    // Coincidence is judged after both pins pass equal synchroniser depth
    if (ext_sel && vs_fall) begin
      nxt_field1 = hs_fall;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      hs_prev_ff <= 1'b1;
      vs_prev_ff <= 1'b1;
      ext_hs_ff  <= 1'b0;
      ext_vs_ff  <= 1'b0;
      field1_ff  <= 1'b0;
    end else begin
      hs_prev_ff <= nxt_hs_prev;
      vs_prev_ff <= nxt_vs_prev;
      ext_hs_ff  <= nxt_ext_hs;
      ext_vs_ff  <= nxt_ext_vs;
      field1_ff  <= nxt_field1;
    end
  end

  // Mode selections
  vdpc_dec_mode_e mode_ff;
  vdpc_dec_mode_e nxt_mode;
  logic [7:0]     bank_ff;
  logic [7:0]     nxt_bank;
  logic           fsc_ff;
  logic           nxt_fsc;

  always_comb begin
    nxt_mode = decode_mode(dec_s);
    nxt_bank = bank_base(bank_s);
    // Clock rate itself is the source's job; only its reading is chosen here
    nxt_fsc = clock_rate_select_in;
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mode_ff <= decode_mode(`VDPC_MODE_ADAPTIVE);
      bank_ff <= bank_base(1'b0);
      fsc_ff  <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      bank_ff <= nxt_bank;
      fsc_ff  <= nxt_fsc;
    end
  end

  // Run state: soft reset bit, function override and resume
  vdpc_run_e  run_ff;
  vdpc_run_e  nxt_run;
  vdpc_run_e  resume_ff;
  vdpc_run_e  nxt_resume;
  logic       srst_ff;
  logic       nxt_srst;
  vdpc_func_t func_ff;
  vdpc_func_t nxt_func;
  logic       first_ff;
  logic       nxt_first;

  always_comb begin
    nxt_run    = run_ff;
    nxt_resume = resume_ff;
    nxt_srst   = srst_ff | soft_reset_set_in;
    nxt_func   = func_ff;
    nxt_first  = 1'b0;
    // Option caught one cycle after release, never under reset itself
    if (first_ff && hardware_reset_option_in) begin
      nxt_srst = 1'b1;
    end
    case (run_ff)
      VDPC_RUN_DISABLED: begin
        if (nxt_srst) begin
          nxt_run = VDPC_RUN_NORMAL;
        end
      end
      VDPC_RUN_NORMAL: begin
        if (!func_n_s) begin
          nxt_resume = VDPC_RUN_NORMAL;
          nxt_func   = func_select_in;
          nxt_run    = VDPC_RUN_FUNCTION;
        end
      end
      VDPC_RUN_FUNCTION: begin
        if (func_n_s) begin
          nxt_run = resume_ff;
        end
      end
      default: begin
        nxt_run = VDPC_RUN_DISABLED;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      run_ff    <= VDPC_RUN_DISABLED;
      resume_ff <= VDPC_RUN_NORMAL;
      srst_ff   <= 1'b0;
      func_ff   <= `VDPC_FUNC_RESET;
      first_ff  <= 1'b1;
    end else begin
      run_ff    <= nxt_run;
      resume_ff <= nxt_resume;
      srst_ff   <= nxt_srst;
      func_ff   <= nxt_func;
      first_ff  <= nxt_first;
    end
  end

  assign video_first_out     = vid_a_ff;
  assign video_second_out    = vid_b_ff;
  assign ext_hsync_out       = ext_hs_ff;
  assign ext_vsync_out       = ext_vs_ff;
  assign field_one_out       = field1_ff;
  assign decoder_mode_out    = mode_ff;
  assign matrix_reg_base_out = bank_ff;
  assign fsc_clock_mode_out  = fsc_ff;
  assign func_active_out     = (run_ff == VDPC_RUN_FUNCTION);
  assign func_code_out       = func_ff;
  assign soft_reset_bit_out  = srst_ff;
  assign outputs_enable_out  = (run_ff != VDPC_RUN_DISABLED);
endmodule

// ### bench/vdpc_src_model.sv
// Sync source model: drives active-low sync pulses on request
`timescale 1ns/100ps
module vdpc_src_model (
  input  wire logic       core_clk_in,
  input  wire logic       go_in,
  input  wire logic [1:0] kind_in,
  output logic            hsync_n_out = 1'b1,
  output logic            vsync_n_out = 1'b1
);
  logic [3:0] cnt_ff = 4'h0;
  // Pins move on the falling edge, away from the sampling edge
  always @(negedge core_clk_in) begin
    if (go_in && cnt_ff == 4'h0) begin
      cnt_ff <= 4'h8;
      hsync_n_out <= !kind_in[0];
      vsync_n_out <= !kind_in[1];
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
      if (cnt_ff == 4'h1) begin
        hsync_n_out <= 1'b1;
        vsync_n_out <= 1'b1;
      end
    end
  end
endmodule

// ### bench/vdpc_top_sva.sv
// Checker for the video decoder pin control block
`timescale 1ns/100ps
module vdpc_top_sva (
  input wire logic                     core_clk_in,
  input wire logic                     reset_in,
  input wire vdpc_pkg::vdpc_pixel_t    video_in_first_in,
  input wire logic                     eight_bit_part_in,
  input wire logic                     hsync_n_in,
  input wire logic                     vsync_n_in,
  input wire logic [1:0]               sync_source_select_in,
  input wire logic [1:0]               decoder_type_in,
  input wire logic                     matrix_bank_in,
  input wire logic                     func_pin_n_in,
  input wire vdpc_pkg::vdpc_func_t     func_select_in,
  input wire logic                     hardware_reset_option_in,
  input wire vdpc_pkg::vdpc_pixel_t    video_first_out,
  input wire logic                     ext_hsync_out,
  input wire logic                     ext_vsync_out,
  input wire logic                     field_one_out,
  input wire vdpc_pkg::vdpc_dec_mode_e decoder_mode_out,
  input wire logic [7:0]               matrix_reg_base_out,
  input wire logic                     func_active_out,
  input wire vdpc_pkg::vdpc_func_t     func_code_out,
  input wire logic                     soft_reset_bit_out,
  input wire logic                     outputs_enable_out
);
  import vdpc_pkg::*;
  logic [2:0] up_ff;
  // Skip pipeline fill after reset
  always_ff @(posedge core_clk_in) begin
    if (reset_in) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_both;
    $fell(vsync_n_in) && $fell(hsync_n_in) && sync_source_select_in == 2'h0;
  endsequence
  sequence s_release;
    $fell(reset_in) && hardware_reset_option_in;
  endsequence
  property p_video;
    up_ff == 3'h7 |-> video_first_out == ($past(eight_bit_part_in) ?
      {$past(video_in_first_in[9:2]), 2'h0} : $past(video_in_first_in));
  endproperty
  property p_hs;
    $fell(hsync_n_in) && sync_source_select_in == 2'h0 |-> ##3 ext_hsync_out;
  endproperty
  property p_src;
    ext_vsync_out |-> $past(sync_source_select_in) == 2'h0;
  endproperty
  property p_field;
    s_both |-> ##3 field_one_out && ext_vsync_out;
  endproperty
  property p_mode;
    up_ff == 3'h7 |-> decoder_mode_out == $past(decoder_type_in, 3);
  endproperty
  property p_bank;
    up_ff == 3'h7 |-> matrix_reg_base_out == ($past(matrix_bank_in, 3) ? 8'h27 : 8'h17);
  endproperty
  property p_func;
    $fell(func_pin_n_in) && outputs_enable_out |->
      ##3 func_active_out && func_code_out == $past(func_select_in);
  endproperty
  property p_resume;
    $rose(func_pin_n_in) |-> ##3 !func_active_out;
  endproperty
  property p_soft;
    s_release |-> ##[1:3] soft_reset_bit_out ##1 outputs_enable_out;
  endproperty
  property p_en;
    outputs_enable_out |-> soft_reset_bit_out;
  endproperty
  a_video: assert property (p_video) else $error("video path wrong");
  a_hs: assert property (p_hs) else $error("no hsync pulse");
  a_src: assert property (p_src) else $error("vsync used off source 00");
  a_field: assert property (p_field) else $error("field one missed");
  a_mode: assert property (p_mode) else $error("mode wrong");
  a_bank: assert property (p_bank) else $error("bank base wrong");
  a_func: assert property (p_func) else $error("function not active");
  a_resume: assert property (p_resume) else $error("no resume");
  a_soft: assert property (p_soft) else $error("no auto start");
  a_en: assert property (p_en) else $error("enable without soft bit");
endmodule
bind vdpc_top vdpc_top_sva vdpc_top_sva_inst (.*);

// ### bench/vdpc_top_tb.sv
// Testbench for the video decoder pin control block
`timescale 1ns/100ps
module vdpc_top_tb;
  import vdpc_pkg::*;
  typedef struct packed {
    logic e; logic [9:0] v; logic [1:0] d; logic b; logic [9:0] xv; logic [7:0] xb;
  } vdpc_row_s;
  vdpc_row_s rows [4] = '{'{1'b0, 10'h3FF, 2'h0, 1'b0, 10'h3FF, 8'h17},
    '{1'b1, 10'h3FF, 2'h1, 1'b1, 10'h3FC, 8'h27}, '{1'b1, 10'h2A5, 2'h2, 1'b0, 10'h2A4, 8'h17},
    '{1'b0, 10'h001, 2'h3, 1'b1, 10'h001, 8'h27}};
  logic           core_clk_in = 1'b0, reset_in = 1'b1, go = 1'b0;
  vdpc_pixel_t    video_in_first_in = '0, video_in_second_in = '0;
  logic           eight_bit_part_in = 1'b0, matrix_bank_in = 1'b0, clock_rate_select_in = 1'b0;
  logic           func_pin_n_in = 1'b1, hardware_reset_option_in = 1'b0, soft_reset_set_in = 1'b0;
  logic [1:0]     sync_source_select_in = 2'h0, decoder_type_in = 2'h0, kind = 2'h0;
  vdpc_func_t     func_select_in = 4'h0, func_code_out;
  logic           hsync_n_in, vsync_n_in, ext_hsync_out, ext_vsync_out, field_one_out;
  logic           fsc_clock_mode_out, func_active_out, soft_reset_bit_out, outputs_enable_out;
  vdpc_pixel_t    video_first_out, video_second_out;
  vdpc_dec_mode_e decoder_mode_out;
  logic [7:0]     matrix_reg_base_out;
  int             error_cnt = 0, check_count = 0, cyc = 0;
  vdpc_top vdpc_top_inst (.*);
  vdpc_src_model vdpc_src_model_inst (.core_clk_in(core_clk_in), .go_in(go), .kind_in(kind),
    .hsync_n_out(hsync_n_in), .vsync_n_out(vsync_n_in));
  // Source-supplied master clock, one rate for both clock readings
  initial forever #12.5 core_clk_in = !core_clk_in;
  task tk(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task endt(input string s);
    $display("test %s done", s);
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Count pulses over a window, since pulses last one cycle only
  task sy(input logic [1:0] k, input int xh, input int xv, input logic xf);
    int h, v;
    h = 0;
    v = 0;
    go <= 1'b1;
    kind <= k;
    tk(1);
    go <= 1'b0;
    repeat (12) begin
      tk(1);
      h += ext_hsync_out;
      v += ext_vsync_out;
    end
    chk(10'(h), 10'(xh));
    chk(10'(v), 10'(xv));
    chk(10'(field_one_out), 10'(xf));
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    tk(5);
    reset_in = 1'b0;
    for (int i = 0; i < 4; i++) begin
      eight_bit_part_in = rows[i].e;
      video_in_first_in = rows[i].v;
      video_in_second_in = ~rows[i].v;
      decoder_type_in = rows[i].d;
      matrix_bank_in = rows[i].b;
      tk(4);
      chk(video_first_out, rows[i].xv);
      chk(video_second_out, ~rows[i].v & (rows[i].e ? 10'h3FC : 10'h3FF));
      chk(10'(decoder_mode_out), 10'(rows[i].d));
      chk(10'(matrix_reg_base_out), 10'(rows[i].xb));
    end
    endt("table");
    sy(2'h3, 1, 1, 1'b1);
    sync_source_select_in = 2'h3;
    tk(4);
    sy(2'h3, 0, 0, 1'b1);
    sync_source_select_in = 2'h0;
    tk(4);
    sy(2'h2, 0, 1, 1'b0);
    endt("sync");
    chk(10'({soft_reset_bit_out, outputs_enable_out}), 10'h000);
    soft_reset_set_in = 1'b1;
    tk(1);
    soft_reset_set_in = 1'b0;
    tk(5);
    chk(10'({soft_reset_bit_out, outputs_enable_out}), 10'h003);
    func_select_in = 4'hA;
    func_pin_n_in = 1'b0;
    tk(5);
    chk(10'(func_active_out), 10'h001);
    chk(10'(func_code_out), 10'h00A);
    func_pin_n_in = 1'b1;
    tk(5);
    chk(10'(func_active_out), 10'h000);
    endt("function");
    clock_rate_select_in = 1'b1;
    tk(5);
    chk(10'(fsc_clock_mode_out), 10'h001);
    endt("clock");
    hardware_reset_option_in = 1'b1;
    reset_in = 1'b1;
    tk(2);
    chk(10'({soft_reset_bit_out, outputs_enable_out}), 10'h000);
    chk(10'(matrix_reg_base_out), 10'h017);
    reset_in = 1'b0;
    tk(5);
    chk(10'({soft_reset_bit_out, outputs_enable_out}), 10'h003);
    endt("reset");
    results();
  end
endmodule
